// >>> sfd_pkg.sv
// ****************************************************************
// Constants shared by the sample FIFO block
// ****************************************************************
package sfd_pkg;

  // ****************************************************************
  // Register offsets on the register port
  // ****************************************************************
  localparam logic [7:0] OFS_PRESS_HIGH  = 8'h01;
  localparam logic [7:0] OFS_ALIAS_FIRST = 8'h02;
  localparam logic [7:0] OFS_ALIAS_LAST  = 8'h05;
  localparam logic [7:0] OFS_TCHG_HIGH   = 8'h0A;
  localparam logic [7:0] OFS_TCHG_LOW    = 8'h0B;
  localparam logic [7:0] OFS_PART_ID     = 8'h0C;
  localparam logic [7:0] OFS_FIFO_COND   = 8'h0D;
  localparam logic [7:0] OFS_FIFO_PORT   = 8'h0E;
  localparam logic [7:0] OFS_FIFO_CFG    = 8'h0F;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int OVF_BIT     = 7;
  localparam int MARK_BIT    = 6;
  localparam int MODE_HI     = 7;
  localparam int MODE_LO     = 6;
  localparam int THRESH_HI   = 5;
  localparam int CHG_FRAC_LO = 4;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int             SAMPLE_W     = 40;
  localparam int             SAMPLE_BYTES = 5;
  localparam int             STORE_DEPTH  = 32;
  localparam int             STAGE_DEPTH  = 4;
  localparam int             CNT_W        = 6;
  localparam logic [5:0]     STORE_FULL   = 6'h20;
  localparam logic [2:0]     LAST_BYTE    = 3'h4;
  localparam logic [7:0]     CFG_RESET    = 8'h00;
  localparam logic [11:0]    CHG_RESET    = 12'h000;
  localparam logic [7:0]     EMPTY_BYTE   = 8'h00;

  // Overflow policy field encodings
  typedef enum logic [1:0] {
    SFD_MODE_OFF    = 2'b00,
    SFD_MODE_CIRC   = 2'b01,
    SFD_MODE_STOP   = 2'b10,
    SFD_MODE_UNUSED = 2'b11
  } sfd_mode_t;

endpackage : sfd_pkg

// >>> sfd_fifo.sv
`timescale 1ns/100ps
// ****************************************************************
// Flop-based FIFO with valid/ready on both sides
// ****************************************************************
module sfd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData,
  output logic [CW-1:0]         count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wrPtr_ff;
  logic [PW-1:0]    rdPtr_ff;
  logic [CW-1:0]    count_ff;
  logic             doPush;
  logic             doPop;

  // Full may still take a word when the head leaves in the same cycle
  assign inReady  = (count_ff != FULL_CNT) || outReady;
  assign outValid = (count_ff != '0);
  assign outData  = mem_ff[rdPtr_ff];
  assign count    = count_ff;
  assign doPush   = inValid && inReady && !flush;
  assign doPop    = outValid && outReady && !flush;

  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else if (flush) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (doPush) begin
        wrPtr_ff <= (wrPtr_ff == LAST_PTR) ? '0 : wrPtr_ff + PW'(1);
      end
      if (doPop) begin
        rdPtr_ff <= (rdPtr_ff == LAST_PTR) ? '0 : rdPtr_ff + PW'(1);
      end
      if (doPush && !doPop) begin
        count_ff <= count_ff + CW'(1);
      end else if (doPop && !doPush) begin
        count_ff <= count_ff - CW'(1);
      end
    end
  end

endmodule : sfd_fifo

// >>> sfd_sample_fifo.sv
`timescale 1ns/100ps
// Contract
// - Temperature change kept as 12-bit signed, integer high byte, fraction bits 7:4 low.
// - Temperature change updates on every sample regardless of FIFO mode.
// - Read-only 8-bit identifier fixed at build, never written by host.
// - Status bit 7 shows overflow while the FIFO stays full.
// - Status bit 6 shows watermark while count exceeds threshold.
// - Status read clears the FIFO interrupt cause; level flags keep following conditions.
// - Status bits 5:0 hold the stored sample count, 0 to 32.
// - FIFO holds up to 32 five-byte samples, read through 8-bit port.
// - With FIFO enabled, data served at 01h; 02h to 05h read 00h.
// - New samples keep entering the FIFO during host data reads.
// - Byte reads give pressure high, mid, low, temperature high, low, then next sample.
// - Exceeding the watermark never halts storage.
// - Samples are pushed at the acquisition interval chosen by system control.
// - Reading returns oldest data, removes it and decrements count by one.
// - Config: policy bits 7:6, threshold bits 5:0, both reset to zero.
// - Policy 00 off, 01 circular overwrite, 10 refuse when full, 11 unused.
// - Disable or standby-to-active flushes FIFO, clearing flags and count.
// - Threshold zero suppresses the watermark flag.
module sfd_sample_fifo #(
  parameter logic [7:0] PART_ID = 8'h5A  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regRd,
  input  wire logic        regWr,
  input  wire logic [7:0]  regWdata,
  output logic [7:0]       regRdata,
  input  wire logic        sampleValid,
  output logic             sampleReady,
  input  wire logic [19:0] samplePressure,
  input  wire logic [11:0] sampleTemp,
  input  wire logic        sysActive,
  output logic             fifoIntPend
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sfd_pkg::sfd_mode_t        mode_ff;
  logic [5:0]                levelThreshold_ff;
  logic [11:0]               tempChangeValue_ff;
  logic [11:0]               prevTemp_ff;
  logic [7:0]                regRdata_ff;
  logic [2:0]                byteIdx_ff;
  logic                      activePrev_ff;
  logic                      eventPrev_ff;
  logic                      fifoIntPend_ff;
  logic [sfd_pkg::SAMPLE_W-1:0] packedSample;
  logic [sfd_pkg::SAMPLE_W-1:0] stgData;
  logic [sfd_pkg::SAMPLE_W-1:0] storeData;
  logic                      stgValid;
  logic                      stgReady;
  logic                      storeIn;
  logic                      storeInReady;
  logic                      storeValid;
  logic                      storePop;
  logic [5:0]                sampleCount;
  logic                      modeEn;
  logic                      storeFull;
  logic                      dataRead;
  logic                      hostPop;
  logic                      circDrop;
  logic                      storeFlush;
  logic                      cfgWrite;
  logic                      fifoOverflowFlag;
  logic                      levelMarkFlag;
  logic                      fifoEvent;
  logic                      sampleTaken;
  logic [1:0]                nxt_modeField;
  logic [7:0]                headByte;
  logic [7:0]                nxt_rdata;

  // ****************************************************************
  // Sample intake and staging buffer
  // ****************************************************************
  // Bytes in read order, unused low nibbles read as zero
  assign packedSample = {samplePressure, 4'h0, sampleTemp, 4'h0};
  assign sampleTaken  = sampleValid && sampleReady;

  // Staging absorbs strobes while the store is busy with a host pop
  sfd_fifo #(
    .WIDTH (sfd_pkg::SAMPLE_W),
    .DEPTH (sfd_pkg::STAGE_DEPTH),
    .CW    (3)
  ) uStage (
    .clk      (clk),
    .rst_n    (rst_n),
    .flush    (1'b0),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .inData   (packedSample),
    .outValid (stgValid),
    .outReady (stgReady),
    .outData  (stgData),
    .count    ()
  );

  // ****************************************************************
  // Mode decode and store control
  // ****************************************************************
  assign modeEn    = (mode_ff == sfd_pkg::SFD_MODE_CIRC) || (mode_ff == sfd_pkg::SFD_MODE_STOP);
  assign storeFull = (sampleCount == sfd_pkg::STORE_FULL);
  assign dataRead  = regRd && modeEn &&
                     ((regAddr == sfd_pkg::OFS_PRESS_HIGH) || (regAddr == sfd_pkg::OFS_FIFO_PORT));
  // Sample leaves only after its fifth byte
  assign hostPop   = dataRead && storeValid && (byteIdx_ff == sfd_pkg::LAST_BYTE);
  // Drain stalls only for the single pop cycle, so intake stops only when staging is full in a pop cycle
  assign stgReady  = !hostPop;
  // Watermark plays no part here; only the policy decides
  assign storeIn   = stgValid && stgReady && modeEn &&
                     (!storeFull || (mode_ff == sfd_pkg::SFD_MODE_CIRC));
  // Circular mode drops the oldest entry to make room
  assign circDrop  = storeIn && storeFull;
  assign storePop  = hostPop || circDrop;

  // Samples are up to 32 deep
  sfd_fifo #(
    .WIDTH (sfd_pkg::SAMPLE_W),
    .DEPTH (sfd_pkg::STORE_DEPTH),
    .CW    (sfd_pkg::CNT_W)
  ) uStore (
    .clk      (clk),
    .rst_n    (rst_n),
    .flush    (storeFlush),
    .inValid  (storeIn),
    .inReady  (storeInReady),
    .inData   (stgData),
    .outValid (storeValid),
    .outReady (storePop),
    .outData  (storeData),
    .count    (sampleCount)
  );

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  assign cfgWrite = regWr && (regAddr == sfd_pkg::OFS_FIFO_CFG);
  assign nxt_modeField = regWdata[sfd_pkg::MODE_HI:sfd_pkg::MODE_LO];

  // Direct switch between the two running policies is refused
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff           <= sfd_pkg::sfd_mode_t'(sfd_pkg::CFG_RESET[sfd_pkg::MODE_HI:sfd_pkg::MODE_LO]);
      levelThreshold_ff <= sfd_pkg::CFG_RESET[sfd_pkg::THRESH_HI:0];
    end else if (cfgWrite) begin
      levelThreshold_ff <= regWdata[sfd_pkg::THRESH_HI:0];
      if ((mode_ff == sfd_pkg::SFD_MODE_OFF) || (nxt_modeField == sfd_pkg::SFD_MODE_OFF)) begin
        mode_ff <= sfd_pkg::sfd_mode_t'(nxt_modeField);
      end
    end
  end

  // Flush on disable or on entering active
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      activePrev_ff <= 1'b0;
    end else begin
      activePrev_ff <= sysActive;
    end
  end

  assign storeFlush = (cfgWrite && (nxt_modeField == sfd_pkg::SFD_MODE_OFF) && modeEn) ||
                      (sysActive && !activePrev_ff);

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Both are levels; flush empties the store so they fall with it
  assign fifoOverflowFlag = modeEn && storeFull;
  assign levelMarkFlag    = (levelThreshold_ff != 6'h00) && (sampleCount > levelThreshold_ff);
  assign fifoEvent        = fifoOverflowFlag || levelMarkFlag;

  // Interrupt cause is edge set, cleared by status read, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eventPrev_ff   <= 1'b0;
      fifoIntPend_ff <= 1'b0;
    end else begin
      eventPrev_ff <= fifoEvent;
      if (fifoEvent && !eventPrev_ff) begin
        fifoIntPend_ff <= 1'b1;
      end else if (regRd && (regAddr == sfd_pkg::OFS_FIFO_COND)) begin
        fifoIntPend_ff <= 1'b0;
      end
    end
  end

  assign fifoIntPend = fifoIntPend_ff;

  // ****************************************************************
  // Byte position within the head sample
  // ****************************************************************
  // Restart at byte 0 when the head changes under the reader
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byteIdx_ff <= 3'h0;
    end else if (storeFlush || circDrop || hostPop) begin
      byteIdx_ff <= 3'h0;
    end else if (dataRead && storeValid) begin
      byteIdx_ff <= byteIdx_ff + 3'h1;
    end
  end

  // Head byte, most significant first
  always_comb begin
    case (byteIdx_ff)
      3'h0:    headByte = storeData[39:32];
      3'h1:    headByte = storeData[31:24];
      3'h2:    headByte = storeData[23:16];
      3'h3:    headByte = storeData[15:8];
      3'h4:    headByte = storeData[7:0];
      default: headByte = sfd_pkg::EMPTY_BYTE;
    endcase
  end

  // ****************************************************************
  // Temperature change tracking
  // ****************************************************************
  // Runs on every taken sample, independent of the policy field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tempChangeValue_ff <= sfd_pkg::CHG_RESET;
      prevTemp_ff        <= sfd_pkg::CHG_RESET;
    end else if (sampleTaken) begin
      tempChangeValue_ff <= sampleTemp - prevTemp_ff;
      prevTemp_ff        <= sampleTemp;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Real-time data lives elsewhere, so 01h..05h read zero when off
  always_comb begin
    nxt_rdata = sfd_pkg::EMPTY_BYTE;
    if (dataRead) begin
      nxt_rdata = storeValid ? headByte : sfd_pkg::EMPTY_BYTE;
    end else if ((regAddr >= sfd_pkg::OFS_ALIAS_FIRST) && (regAddr <= sfd_pkg::OFS_ALIAS_LAST)) begin
      nxt_rdata = sfd_pkg::EMPTY_BYTE;
    end else begin
      case (regAddr)
        sfd_pkg::OFS_TCHG_HIGH: nxt_rdata = tempChangeValue_ff[11:4];
        sfd_pkg::OFS_TCHG_LOW:  nxt_rdata = {tempChangeValue_ff[3:0], 4'h0};
        sfd_pkg::OFS_PART_ID:   nxt_rdata = PART_ID;
        sfd_pkg::OFS_FIFO_COND: nxt_rdata = {fifoOverflowFlag, levelMarkFlag, sampleCount};
        sfd_pkg::OFS_FIFO_CFG:  nxt_rdata = {mode_ff, levelThreshold_ff};
        default:                nxt_rdata = sfd_pkg::EMPTY_BYTE;
      endcase
    end
  end

  // Read data held until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata_ff <= sfd_pkg::EMPTY_BYTE;
    end else if (regRd) begin
      regRdata_ff <= nxt_rdata;
    end
  end

  assign regRdata = regRdata_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_delta_value: assert property (@(posedge clk) disable iff (!rst_n)
    sampleTaken |=> tempChangeValue_ff == 12'($past(sampleTemp) - $past(prevTemp_ff)))
    else $error("temperature change wrong");

  a_delta_off_mode: assert property (@(posedge clk) disable iff (!rst_n)
    sampleTaken && !modeEn |=> prevTemp_ff == $past(sampleTemp))
    else $error("change not tracked while FIFO off");

  a_part_id: assert property (@(posedge clk) disable iff (!rst_n)
    regRd && regAddr == sfd_pkg::OFS_PART_ID |=> regRdata == PART_ID)
    else $error("identifier read wrong");

  a_ovf_status: assert property (@(posedge clk) disable iff (!rst_n)
    regRd && regAddr == sfd_pkg::OFS_FIFO_COND |=> regRdata[7] == $past(modeEn && sampleCount == 6'h20))
    else $error("overflow bit wrong");

  a_mark_status: assert property (@(posedge clk) disable iff (!rst_n)
    regRd && regAddr == sfd_pkg::OFS_FIFO_COND && levelThreshold_ff != 6'h00
      |=> regRdata[6] == ($past(sampleCount) > $past(levelThreshold_ff)))
    else $error("watermark bit wrong");

  a_cause_clear: assert property (@(posedge clk) disable iff (!rst_n)
    regRd && regAddr == sfd_pkg::OFS_FIFO_COND && !(fifoEvent && !eventPrev_ff) |=> !fifoIntPend)
    else $error("cause not cleared by status read");

  a_count_range: assert property (@(posedge clk) disable iff (!rst_n)
    sampleCount <= 6'h20)
    else $error("count above 32");

  a_alias_zero: assert property (@(posedge clk) disable iff (!rst_n)
    regRd && modeEn && regAddr >= 8'h02 && regAddr <= 8'h05 |=> regRdata == 8'h00)
    else $error("alias address not zero");

  a_pop_count: assert property (@(posedge clk) disable iff (!rst_n)
    hostPop && !storeFlush |=> sampleCount == $past(sampleCount) - 6'h01)
    else $error("pop did not decrement count");

  a_stop_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    mode_ff == sfd_pkg::SFD_MODE_STOP && sampleCount == 6'h20 |-> !storeIn)
    else $error("full stop mode took a sample");

  a_circ_full: assert property (@(posedge clk) disable iff (!rst_n)
    circDrop && !storeFlush |=> sampleCount == 6'h20)
    else $error("circular overwrite changed count");

  a_flush_empty: assert property (@(posedge clk) disable iff (!rst_n)
    storeFlush |=> sampleCount == 6'h00 && !fifoOverflowFlag && !levelMarkFlag)
    else $error("flush left data");

  a_mark_zero: assert property (@(posedge clk) disable iff (!rst_n)
    levelThreshold_ff == 6'h00 |-> !levelMarkFlag)
    else $error("watermark with zero threshold");

  a_empty_read: assert property (@(posedge clk) disable iff (!rst_n)
    dataRead && sampleCount == 6'h00 |=> regRdata == 8'h00)
    else $error("empty read not zero");

  a_intake_open: assert property (@(posedge clk) disable iff (!rst_n)
    hostPop |=> stgReady)
    else $error("drain stalled two cycles");

  a_store_ready: assert property (@(posedge clk) disable iff (!rst_n)
    storeIn |-> storeInReady)
    else $error("store refused a push");

  a_cause_set: assert property (@(posedge clk) disable iff (!rst_n)
    fifoEvent && !eventPrev_ff |=> fifoIntPend)
    else $error("cause not raised on event");

endmodule : sfd_sample_fifo

// >>> sfd_sample_src.sv
`timescale 1ns/100ps
// *****
// Acquisition engine stand-in
// *****
module sfd_sample_src (
  input  wire logic   clk,
  input  wire logic   sampleReady,
  output logic        sampleValid,
  output logic [19:0] samplePressure,
  output logic [11:0] sampleTemp
);
  int misses = 0;  // Offers never taken

  // Quiet lines at time zero
  initial begin
    sampleValid = 1'b0;
    samplePressure = 20'h00000;
    sampleTemp = 12'h000;
  end

  // Offer one sample, held until taken; valid stays up so offers can chain
  task automatic send(input logic [19:0] p, input logic [11:0] t);
    int n;
    n = 0;
    sampleValid = 1'b1;
    samplePressure = p;
    sampleTemp = t;
    while (sampleReady !== 1'b1 && n < 64) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 64) misses++;
    @(posedge clk);
    #1;
  endtask : send

  // Release: lines show the inverse so stale data never passes for new
  task automatic rest();
    sampleValid = 1'b0;
    samplePressure = ~samplePressure;
    sampleTemp = ~sampleTemp;
  endtask : rest
endmodule : sfd_sample_src

// >>> sfd_sample_fifo_tb_top.sv
`timescale 1ns/100ps
// *****
// Bench for the sample FIFO block
// *****
module sfd_sample_fifo_tb_top;
  localparam logic [7:0] ID_VAL = 8'hA7;  // Arbitrary value

  logic        clk;
  logic        rst_n;
  logic [7:0]  regAddr;
  logic        regRd;
  logic        regWr;
  logic [7:0]  regWdata;
  logic [7:0]  regRdata;
  logic        sampleValid;
  logic        sampleReady;
  logic [19:0] samplePressure;
  logic [11:0] sampleTemp;
  logic        sysActive;
  logic        fifoIntPend;
  int          errors = 0;
  int          checked = 0;
  // Addresses that must read zero straight after reset
  logic [7:0]  rstAddr [7] = '{8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h0F, 8'h01, 8'h20};

  sfd_sample_fifo #(.PART_ID(ID_VAL)) DUT (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regRd(regRd), .regWr(regWr),
    .regWdata(regWdata), .regRdata(regRdata), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .samplePressure(samplePressure),
    .sampleTemp(sampleTemp), .sysActive(sysActive), .fifoIntPend(fifoIntPend));

  sfd_sample_src src (
    .clk(clk), .sampleReady(sampleReady), .sampleValid(sampleValid),
    .samplePressure(samplePressure), .sampleTemp(sampleTemp));

  // 50 MHz clock
  always #10 clk = ~clk;

  // *****
  // Helpers
  // *****
  // Sample i: pressure {1,i,i}, temperature {i,5}
  function automatic logic [7:0] sb(input int i, input int k);
    logic [19:0] p;
    logic [11:0] t;
    p = {4'h1, i[7:0], i[7:0]};
    t = {i[7:0], 4'h5};
    case (k)
      0: sb = p[19:12];
      1: sb = p[11:4];
      2: sb = {p[3:0], 4'h0};
      3: sb = t[11:4];
      default: sb = {t[3:0], 4'h0};
    endcase
  endfunction : sb

  task automatic push(input int i);
    src.send({4'h1, i[7:0], i[7:0]}, {i[7:0], 4'h5});
  endtask : push

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Strobe stays up so reads can run back to back
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    regAddr = a;
    regRd = 1'b1;
    @(posedge clk);
    #1;
    chk(regRdata, e);
  endtask : rdchk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regRd = 1'b0;
    regAddr = a;
    regWdata = d;
    regWr = 1'b1;
    @(posedge clk);
    #1;
    regWr = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  // Staging drains within a few cycles, so twelve covers any wait here
  task automatic idle(input int n);
    regRd = 1'b0;
    src.rest();
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic give_verdict();
    errors += src.misses;
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // Hang guard
  initial begin
    #200000;
    errors++;
    give_verdict();
  end

  // *****
  // Main sequence
  // *****
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    regAddr = 8'h00;
    regRd = 1'b0;
    regWr = 1'b0;
    regWdata = 8'h00;
    sysActive = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk({7'h00, sampleReady}, 8'h01);
    foreach (rstAddr[j])
      rdchk(rstAddr[j], 8'h00);
    rdchk(8'h0C, ID_VAL);
    wr(8'h0C, 8'hFF);
    rdchk(8'h0C, ID_VAL);
    // Change registers with the FIFO off
    push(8'h12);
    idle(12);
    rdchk(8'h0A, 8'h12);
    rdchk(8'h0B, 8'h50);
    push(8'h10);
    idle(12);
    rdchk(8'h0A, 8'hFE);
    rdchk(8'h0B, 8'h00);
    rdchk(8'h0D, 8'h00);
    // Unused policy code must behave as off
    wr(8'h0F, 8'hC0);
    rdchk(8'h0F, 8'hC0);
    push(8'h11);
    idle(12);
    rdchk(8'h0D, 8'h00);
    wr(8'h0F, 8'h00);
    // Circular mode, threshold 3
    wr(8'h0F, 8'h43);
    rdchk(8'h0F, 8'h43);
    for (int i = 0; i < 5; i++) push(i);
    idle(12);
    chk({7'h00, fifoIntPend}, 8'h01);
    rdchk(8'h0D, 8'h45);
    chk({7'h00, fifoIntPend}, 8'h00);
    rdchk(8'h0D, 8'h45);
    for (int k = 0; k < 5; k++) rdchk(8'h01, sb(0, k));
    rdchk(8'h02, 8'h00);
    rdchk(8'h05, 8'h00);
    rdchk(8'h0D, 8'h44);
    for (int k = 0; k < 5; k++) rdchk(8'h0E, sb(1, k));
    rdchk(8'h0D, 8'h03);
    idle(1);
    for (int i = 5; i < 35; i++) push(i);
    idle(12);
    rdchk(8'h0D, 8'hE0);
    wr(8'h0F, 8'h83);
    rdchk(8'h0F, 8'h43);
    for (int j = 3; j < 35; j++)
      for (int k = 0; k < 5; k++) rdchk(8'h0E, sb(j, k));
    rdchk(8'h0D, 8'h00);
    rdchk(8'h0E, 8'h00);
    rdchk(8'h0D, 8'h00);
    // Refuse-when-full mode, threshold 0
    wr(8'h0F, 8'h00);
    wr(8'h0F, 8'h80);
    for (int i = 40; i < 74; i++) push(i);
    idle(12);
    rdchk(8'h0D, 8'hA0);
    rdchk(8'h0E, sb(40, 0));
    wr(8'h0F, 8'h00);
    rdchk(8'h0D, 8'h00);
    // Accumulation continues while data is read out
    wr(8'h0F, 8'h41);
    push(90);
    push(91);
    idle(12);
    rdchk(8'h0D, 8'h42);
    fork
      for (int k = 0; k < 5; k++) rdchk(8'h0E, sb(90, k));
      begin
        push(92);
        src.rest();
      end
    join
    idle(12);
    rdchk(8'h0D, 8'h42);
    idle(1);
    sysActive = 1'b0;
    idle(2);
    sysActive = 1'b1;
    idle(2);
    rdchk(8'h0D, 8'h00);
    idle(1);
    give_verdict();
  end
endmodule : sfd_sample_fifo_tb_top
